/* design/pwl_link_port.sv */
// Link-side command port: takes decoded bus commands on the link clock
// and passes them to the core by a toggle handshake.
// Assumes: a protocol engine on link_clk presents one command per cmd_valid pulse.
`timescale 1ns/1ps
`default_nettype none
module pwl_link_port (
    input  wire logic               link_clk,
    input  wire logic               rstn,
    input  wire logic               cmd_valid,
    input  wire pwl_pkg::pwl_kind_t cmd_kind,
    input  wire logic [7:0]         cmd_code,
    input  wire logic [15:0]        cmd_wdata,
    input  wire logic               cmd_bad,
    output logic                    rsp_valid,
    output logic [15:0]             rsp_rdata,
    output logic                    busy,
    pwl_xfer_if.link                xf
);
    import pwl_pkg::*;

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    logic        req_tgl_r,   req_tgl_nxt;    // Request toggle
    logic [7:0]  code_r,      code_nxt;       // Held command code
    pwl_kind_t   kind_r,      kind_nxt;       // Held kind
    logic [15:0] wdata_r,     wdata_nxt;      // Held write data
    logic        bad_r,       bad_nxt;        // Held error mark
    logic        busy_r,      busy_nxt;       // Request outstanding
    logic        ack_s1_r,    ack_s2_r;       // Ack synchroniser
    logic        ack_s3_r;                    // Ack edge history
    logic        rsp_valid_r, rsp_valid_nxt;  // Answer pulse
    logic [15:0] rsp_rdata_r, rsp_rdata_nxt;  // Answer data
    logic        take;                        // Command accepted
    logic        ack_edge;                    // Answer arrived

    // Next values: accept when idle, finish on ack edge
    always_comb begin
        take          = cmd_valid & ~busy_r;
        ack_edge      = ack_s2_r ^ ack_s3_r;
        req_tgl_nxt   = req_tgl_r ^ take;
        code_nxt      = take ? cmd_code  : code_r;
        kind_nxt      = take ? cmd_kind  : kind_r;
        wdata_nxt     = take ? cmd_wdata : wdata_r;
        bad_nxt       = take ? cmd_bad   : bad_r;
        busy_nxt      = take | (busy_r & ~ack_edge);
        rsp_valid_nxt = ack_edge;
        rsp_rdata_nxt = ack_edge ? xf.rdata : rsp_rdata_r;
    end

    // Registers, link clock domain
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            req_tgl_r   <= 1'b0;
            code_r      <= 8'h00;
            kind_r      <= KIND_READ;
            wdata_r     <= 16'h0000;
            bad_r       <= 1'b0;
            busy_r      <= 1'b0;
            ack_s1_r    <= 1'b0;
            ack_s2_r    <= 1'b0;
            ack_s3_r    <= 1'b0;
            rsp_valid_r <= 1'b0;
            rsp_rdata_r <= RDATA_RST;
        end else begin
            req_tgl_r   <= req_tgl_nxt;
            code_r      <= code_nxt;
            kind_r      <= kind_nxt;
            wdata_r     <= wdata_nxt;
            bad_r       <= bad_nxt;
            busy_r      <= busy_nxt;
            ack_s1_r    <= xf.ack_tgl;
            ack_s2_r    <= ack_s1_r;
            ack_s3_r    <= ack_s2_r;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_rdata_r <= rsp_rdata_nxt;
        end
    end

    // Outputs straight from flops
    assign xf.req_tgl = req_tgl_r;
    assign xf.code    = code_r;
    assign xf.kind    = kind_r;
    assign xf.wdata   = wdata_r;
    assign xf.bad     = bad_r;
    assign rsp_valid  = rsp_valid_r;
    assign rsp_rdata  = rsp_rdata_r;
    assign busy       = busy_r;
endmodule
`default_nettype wire

/* design/pwl_pkg.sv */
// Constants, command codes and types for the warning-limit and summary-status block.
// Assumes: included before every other file of the block.
package pwl_pkg;

    // --------------------------------------------------------------
    // Command codes
    // --------------------------------------------------------------
    localparam logic [7:0]  CMD_OPERATION  = 8'h01;  // Output on/off byte
    localparam logic [7:0]  CMD_CLEAR      = 8'h03;  // Clear latched flags, no data
    localparam logic [7:0]  CMD_OV_THR     = 8'h57;  // input_overvolt_warn_threshold
    localparam logic [7:0]  CMD_UV_THR     = 8'h58;  // input_undervolt_warn_threshold
    localparam logic [7:0]  CMD_OP_THR     = 8'h6b;  // input_overpower_warn_threshold
    localparam logic [7:0]  CMD_STAT_BYTE  = 8'h78;  // summary_status_byte
    localparam logic [7:0]  CMD_STAT_WORD  = 8'h79;  // summary_status_word

    // --------------------------------------------------------------
    // Values after reset
    // --------------------------------------------------------------
    localparam logic [11:0] OV_THR_RST     = 12'hfff;
    localparam logic [11:0] UV_THR_RST     = 12'h000;
    localparam logic [14:0] OP_THR_RST     = 15'h7fff;
    localparam logic        OPER_ON_RST    = 1'b1;
    localparam logic [15:0] RDATA_RST      = 16'h0000;

    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int OPER_ON_BIT = 7;   // Operation: output enable
    localparam int SB_OFF      = 6;   // Status byte: switch_off_flag
    localparam int SB_OC       = 4;   // Status byte: overcurrent_shutdown_flag
    localparam int SB_UVF      = 3;   // Status byte: input_undervolt_fault_flag
    localparam int SB_CML      = 1;   // Status byte: bus_comm_error_flag
    localparam int SB_OTHER    = 0;   // Status byte: other_pending_flag
    localparam int SW_VOUT     = 15;  // Status word: outvolt_group_pending
    localparam int SW_IOUT     = 14;  // Status word: outcurrent_group_pending
    localparam int SW_INPUT    = 13;  // Status word: input group pending
    localparam int SW_MFR      = 12;  // Status word: vendor_group_pending
    localparam int SW_PGN      = 11;  // Status word: power not good
    localparam int IS_OVW      = 6;   // Input status: input_overvolt_warn_flag
    localparam int IS_UVW      = 5;   // Input status: input_undervolt_warn_flag
    localparam int IS_UVF      = 4;   // Input status: undervolt fault
    localparam int IS_OPW      = 0;   // Input status: overpower_warn_flag

    // Number of pin inputs that pass a synchroniser
    localparam int NUM_PINS    = 3;

    // --------------------------------------------------------------
    // Types
    // --------------------------------------------------------------
    typedef enum logic [1:0] {
        KIND_READ  = 2'h0,            // Read byte or word
        KIND_WRITE = 2'h1,            // Write byte or word
        KIND_SEND  = 2'h2             // Send byte, no data
    } pwl_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,             // Waiting for a request
        ST_EXEC  = 2'b01,             // Carrying out the command
        ST_REPLY = 2'b11              // Handing the answer back
    } pwl_state_t;

endpackage

/* design/pwl_top.sv */
// Warning thresholds and summary status for a hot swap power monitor.
// Assumes: measurements and group summaries come from logic on core_clk;
// comparator pins are asynchronous; commands arrive on link_clk.
`timescale 1ns/1ps
`default_nettype none
module pwl_top (
    input  wire logic               core_clk,
    input  wire logic               link_clk,
    input  wire logic               rstn,
    input  wire logic               cmd_valid,
    input  wire pwl_pkg::pwl_kind_t cmd_kind,
    input  wire logic [7:0]         cmd_code,
    input  wire logic [15:0]        cmd_wdata,
    input  wire logic               cmd_bad,
    output logic                    rsp_valid,
    output logic [15:0]             rsp_rdata,
    output logic                    cmd_busy,
    input  wire logic               oc_timeout_pin,
    input  wire logic               uv_cmp_pin,
    input  wire logic               output_feedback_pin,
    input  wire logic               meas_valid,
    input  wire logic [11:0]        vin_code,
    input  wire logic [14:0]        pin_code,
    input  wire logic               outvolt_group_pending,
    input  wire logic               outcurrent_group_pending,
    input  wire logic               vendor_group_pending,
    output logic                    gate_enable,
    output logic                    power_good_pin
);
    import pwl_pkg::*;

    // --------------------------------------------------------------
    // Link-side port and crossing
    // --------------------------------------------------------------
    pwl_xfer_if xf ();

    pwl_link_port u_link (
        .link_clk  (link_clk),
        .rstn      (rstn),
        .cmd_valid (cmd_valid),
        .cmd_kind  (cmd_kind),
        .cmd_code  (cmd_code),
        .cmd_wdata (cmd_wdata),
        .cmd_bad   (cmd_bad),
        .rsp_valid (rsp_valid),
        .rsp_rdata (rsp_rdata),
        .busy      (cmd_busy),
        .xf        (xf.link)
    );

    // --------------------------------------------------------------
    // Command capabilities
    // --------------------------------------------------------------
    // Returns {readable, writable, send-only} for a command code
    function automatic logic [2:0] cmd_caps(input logic [7:0] code);
        logic [2:0] caps;
        caps = 3'h0;
        case (code)
            CMD_OPERATION: caps = 3'h6;
            CMD_OV_THR:    caps = 3'h6;
            CMD_UV_THR:    caps = 3'h6;
            CMD_OP_THR:    caps = 3'h6;
            CMD_STAT_BYTE: caps = 3'h4;
            CMD_STAT_WORD: caps = 3'h4;
            CMD_CLEAR:     caps = 3'h1;
            default:       caps = 3'h0;
        endcase
        return caps;
    endfunction

    // --------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------
    logic [NUM_PINS-1:0] pin_raw;      // Asynchronous comparator pins
    logic [NUM_PINS-1:0] pin_s1_r;     // First stage, read only by second
    logic [NUM_PINS-1:0] pin_s2_r;     // Safe to use
    logic                oc_sync;      // Overcurrent timer expired
    logic                uv_sync;      // Input below undervolt trip
    logic                fb_sync;      // Output feedback above threshold

    assign pin_raw = {oc_timeout_pin, uv_cmp_pin, output_feedback_pin};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_sync
            // Two-flop synchroniser per pin
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    pin_s1_r[gi] <= 1'b0;
                    pin_s2_r[gi] <= 1'b0;
                end else begin
                    pin_s1_r[gi] <= pin_raw[gi];
                    pin_s2_r[gi] <= pin_s1_r[gi];
                end
            end
        end
    endgenerate

    assign oc_sync = pin_s2_r[2];
    assign uv_sync = pin_s2_r[1];
    assign fb_sync = pin_s2_r[0];

    // --------------------------------------------------------------
    // Request edge detection
    // --------------------------------------------------------------
    logic req_s1_r;                    // First stage of request toggle
    logic req_s2_r;                    // Second stage
    logic req_s3_r;                    // Edge history
    logic req_edge;                    // New request seen

    // Toggle synchroniser from the link domain
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_s3_r <= 1'b0;
        end else begin
            req_s1_r <= xf.req_tgl;
            req_s2_r <= req_s1_r;
            req_s3_r <= req_s2_r;
        end
    end

    assign req_edge = req_s2_r ^ req_s3_r;

    // --------------------------------------------------------------
    // Core state
    // --------------------------------------------------------------
    pwl_state_t  state_r,   state_nxt;    // Command sequencer
    logic [11:0] ov_thr_r,  ov_thr_nxt;   // input_overvolt_threshold
    logic [11:0] uv_thr_r,  uv_thr_nxt;   // input_undervolt_threshold
    logic [14:0] op_thr_r,  op_thr_nxt;   // input_overpower_threshold
    logic        oper_on_r, oper_on_nxt;  // Output enable command
    logic        oc_r,      oc_nxt;       // overcurrent_shutdown_flag
    logic        uvf_r,     uvf_nxt;      // input_undervolt_fault_flag
    logic        cml_r,     cml_nxt;      // bus_comm_error_flag
    logic        ovw_r,     ovw_nxt;      // input_overvolt_warn_flag
    logic        uvw_r,     uvw_nxt;      // input_undervolt_warn_flag
    logic        opw_r,     opw_nxt;      // overpower_warn_flag
    logic [15:0] rdata_r,   rdata_nxt;    // Answer to the link
    logic        ack_r,     ack_nxt;      // Answer toggle
    logic        gate_r,    gate_nxt;     // Gate drive enable
    logic        pgood_r,   pgood_nxt;    // Power good pin
    logic [2:0]  caps;                    // Capabilities of held code
    logic        exec;                    // Command being carried out
    logic        wr_ok;                   // Legal write
    logic        clr;                     // Clear command pulse
    logic        cmd_err;                 // Illegal command
    logic        switch_off;              // Gate drive disabled
    logic [7:0]  in_status;               // Input status group
    logic [7:0]  stat_byte;               // Summary status byte
    logic [15:0] stat_word;               // Summary status word
    logic [15:0] rd_val;                  // Read mux

    // Status assembly
    always_comb begin
        switch_off = ~oper_on_r | oc_r | uv_sync;
        in_status  = 8'h00;
        in_status[IS_OVW] = ovw_r;
        in_status[IS_UVW] = uvw_r;
        in_status[IS_UVF] = uvf_r;
        in_status[IS_OPW] = opw_r;
        stat_byte  = 8'h00;
        stat_byte[SB_OFF]   = switch_off;
        stat_byte[SB_OC]    = oc_r;
        stat_byte[SB_UVF]   = uvf_r;
        stat_byte[SB_CML]   = cml_r;
        stat_byte[SB_OTHER] = ovw_r | uvw_r | opw_r | outvolt_group_pending
                            | outcurrent_group_pending | vendor_group_pending;
        stat_word  = {8'h00, stat_byte};
        stat_word[SW_VOUT]  = outvolt_group_pending;
        stat_word[SW_IOUT]  = outcurrent_group_pending | oc_r;
        stat_word[SW_INPUT] = |in_status;
        stat_word[SW_MFR]   = vendor_group_pending;
        stat_word[SW_PGN]   = ~fb_sync;
    end

    // Read mux
    always_comb begin
        case (xf.code)
            CMD_OPERATION: rd_val = {8'h00, oper_on_r, 7'h00};
            CMD_OV_THR:    rd_val = {4'h0, ov_thr_r};
            CMD_UV_THR:    rd_val = {4'h0, uv_thr_r};
            CMD_OP_THR:    rd_val = {1'b0, op_thr_r};
            CMD_STAT_BYTE: rd_val = {8'h00, stat_byte};
            CMD_STAT_WORD: rd_val = stat_word;
            default:       rd_val = 16'h0000;
        endcase
    end

    // Sequencer and register next values
    always_comb begin
        caps      = cmd_caps(xf.code);
        exec      = (state_r == ST_EXEC);
        wr_ok     = exec & ~xf.bad & (xf.kind == KIND_WRITE) & caps[1];
        clr       = exec & ~xf.bad & (xf.kind == KIND_SEND) & caps[0];
        cmd_err   = exec & (xf.bad
                  | ((xf.kind == KIND_READ)  & ~caps[2])
                  | ((xf.kind == KIND_WRITE) & ~caps[1])
                  | ((xf.kind == KIND_SEND)  & ~caps[0])
                  | (xf.kind != KIND_READ && xf.kind != KIND_WRITE && xf.kind != KIND_SEND));
        state_nxt = state_r;
        ack_nxt   = ack_r;
        rdata_nxt = rdata_r;
        case (state_r)
            ST_IDLE: begin
                if (req_edge) begin
                    state_nxt = ST_EXEC;
                end
            end
            ST_EXEC: begin
                // Capture answer, harmless for writes
                rdata_nxt = (xf.kind == KIND_READ && caps[2] && !xf.bad) ? rd_val : 16'h0000;
                state_nxt = ST_REPLY;
            end
            ST_REPLY: begin
                ack_nxt   = ~ack_r;
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase

        // Writable registers
        ov_thr_nxt  = (wr_ok && xf.code == CMD_OV_THR) ? xf.wdata[11:0] : ov_thr_r;
        uv_thr_nxt  = (wr_ok && xf.code == CMD_UV_THR) ? xf.wdata[11:0] : uv_thr_r;
        op_thr_nxt  = (wr_ok && xf.code == CMD_OP_THR) ? xf.wdata[14:0] : op_thr_r;
        oper_on_nxt = (wr_ok && xf.code == CMD_OPERATION) ? xf.wdata[OPER_ON_BIT] : oper_on_r;

        // Latched flags: a set in the clearing cycle wins
        oc_nxt  = oc_sync | (oc_r & ~clr);
        uvf_nxt = uv_sync | (uvf_r & ~clr);
        cml_nxt = cmd_err | (cml_r & ~clr);
        ovw_nxt = (meas_valid & (vin_code > ov_thr_r)) | (ovw_r & ~clr);
        uvw_nxt = (meas_valid & (vin_code < uv_thr_r)) | (uvw_r & ~clr);
        opw_nxt = (meas_valid & (pin_code > op_thr_r)) | (opw_r & ~clr);

        // Live pin outputs
        gate_nxt  = ~switch_off;
        pgood_nxt = fb_sync;
    end

    // Registers, core clock domain
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_r   <= ST_IDLE;
            ov_thr_r  <= OV_THR_RST;
            uv_thr_r  <= UV_THR_RST;
            op_thr_r  <= OP_THR_RST;
            oper_on_r <= OPER_ON_RST;
            oc_r      <= 1'b0;
            uvf_r     <= 1'b0;
            cml_r     <= 1'b0;
            ovw_r     <= 1'b0;
            uvw_r     <= 1'b0;
            opw_r     <= 1'b0;
            rdata_r   <= RDATA_RST;
            ack_r     <= 1'b0;
            gate_r    <= 1'b0;
            pgood_r   <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            ov_thr_r  <= ov_thr_nxt;
            uv_thr_r  <= uv_thr_nxt;
            op_thr_r  <= op_thr_nxt;
            oper_on_r <= oper_on_nxt;
            oc_r      <= oc_nxt;
            uvf_r     <= uvf_nxt;
            cml_r     <= cml_nxt;
            ovw_r     <= ovw_nxt;
            uvw_r     <= uvw_nxt;
            opw_r     <= opw_nxt;
            rdata_r   <= rdata_nxt;
            ack_r     <= ack_nxt;
            gate_r    <= gate_nxt;
            pgood_r   <= pgood_nxt;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign xf.ack_tgl     = ack_r;
    assign xf.rdata       = rdata_r;
    assign gate_enable    = gate_r;
    assign power_good_pin = pgood_r;
endmodule
`default_nettype wire

/* design/pwl_xfer_if.sv */
// Crossing signals between the link-side command port and the core.
// Assumes: request fields held stable while a request toggle is outstanding.
`timescale 1ns/1ps
`default_nettype none
interface pwl_xfer_if;
    import pwl_pkg::*;
    logic              req_tgl;  // Toggles once per request (link clock)
    logic [7:0]        code;     // Command code, stable while pending
    pwl_kind_t         kind;     // Transfer kind, stable while pending
    logic [15:0]       wdata;    // Write data, stable while pending
    logic              bad;      // Malformed or bad check byte
    logic              ack_tgl;  // Toggles once per answer (core clock)
    logic [15:0]       rdata;    // Read data, stable after ack toggle

    modport link (output req_tgl, code, kind, wdata, bad, input ack_tgl, rdata);
    modport core (input req_tgl, code, kind, wdata, bad, output ack_tgl, rdata);
endinterface
`default_nettype wire

/* testbench/pmbus_warn_limits_status_tb.sv */
// Bench for the warning thresholds and summary status block.
// Assumes: package, interface and design modules compiled first.
`timescale 1ns/1ps
`default_nettype none
module pmbus_warn_limits_status_tb;
    import pwl_pkg::*;
    logic core_clk, link_clk, rstn, cmd_valid, cmd_bad, rsp_valid, cmd_busy, gate_enable, power_good_pin;
    logic oc_timeout_pin, uv_cmp_pin, output_feedback_pin, meas_valid;
    logic outvolt_group_pending, outcurrent_group_pending, vendor_group_pending;
    pwl_kind_t cmd_kind;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, rsp_rdata, rd;
    logic [11:0] vin_code;
    logic [14:0] pin_code;
    int n_mismatch = 0, n_tests = 0, cyc = 0;
    pwl_top pwl_top_i (.*);
    pwl_host_model pwl_host_model_i (.*);
    initial begin core_clk = 0; forever #12.5 core_clk = ~core_clk; end
    task automatic check(input logic [15:0] got, exp);
        n_tests++;
        if (got !== exp) begin n_mismatch++; $display("wrong value at %0t: got %h expected %h", $time, got, exp); end
    endtask
    task automatic rc(input logic [7:0] c, input logic [15:0] e, input logic b = 0);
        pwl_host_model_i.xfer(KIND_READ, c, 16'h0000, b, rd);
        check(rd, e);
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d, input pwl_kind_t k = KIND_WRITE);
        pwl_host_model_i.xfer(k, c, d, 1'b0, rd);
        check(rd, 16'h0000);
    endtask
    task automatic meas(input logic [11:0] v, input logic [14:0] p);
        @(posedge core_clk) #1 meas_valid = 1; vin_code = v; pin_code = p;
        @(posedge core_clk) #1 meas_valid = 0; repeat (4) @(posedge core_clk);
    endtask
    task automatic t_reset;
        rc(CMD_OV_THR, 16'h0fff);
        rc(CMD_UV_THR, 16'h0000);
        rc(CMD_OP_THR, 16'h7fff);
        rc(CMD_STAT_BYTE, 16'h0000);
        rc(CMD_STAT_WORD, 16'h0000);
        $display("reset values done");
    endtask
    task automatic t_thr;
        wr(CMD_OV_THR, 16'hffff); rc(CMD_OV_THR, 16'h0fff);
        wr(CMD_UV_THR, 16'hf123); rc(CMD_UV_THR, 16'h0123);
        wr(CMD_OP_THR, 16'h8010); rc(CMD_OP_THR, 16'h0010);
        wr(CMD_OV_THR, 16'h0200); rc(CMD_OV_THR, 16'h0200);
        $display("thresholds done");
    endtask
    task automatic t_warn;
        meas(12'h123, 15'h0010); rc(CMD_STAT_WORD, 16'h0000);
        meas(12'h201, 15'h0011); rc(CMD_STAT_WORD, 16'h2001);
        rc(CMD_STAT_BYTE, 16'h0001);
        wr(CMD_CLEAR, 16'h0000, KIND_SEND); rc(CMD_STAT_WORD, 16'h0000);
        meas(12'h122, 15'h0000); rc(CMD_STAT_WORD, 16'h2001);
        wr(CMD_CLEAR, 16'h0000, KIND_SEND);
        $display("warnings done");
    endtask
    task automatic t_fault;
        @(posedge core_clk) #1 oc_timeout_pin = 1; repeat (8) @(posedge core_clk); #1 oc_timeout_pin = 0;
        check({15'h0000, gate_enable}, 16'h0000);
        uv_cmp_pin = 1; repeat (8) @(posedge core_clk); #1 uv_cmp_pin = 0; repeat (4) @(posedge core_clk);
        rc(CMD_STAT_BYTE, 16'h0058);
        rc(CMD_STAT_WORD, 16'h6058);
        wr(CMD_CLEAR, 16'h0000, KIND_SEND); rc(CMD_STAT_BYTE, 16'h0000);
        $display("faults done");
    endtask
    task automatic t_misc;
        wr(CMD_OPERATION, 16'h0000); rc(CMD_STAT_BYTE, 16'h0040);
        wr(CMD_OPERATION, 16'h0080); rc(CMD_STAT_BYTE, 16'h0000);
        rc(8'hee, 16'h0000); rc(CMD_STAT_BYTE, 16'h0002);
        wr(CMD_CLEAR, 16'h0000, KIND_SEND); rc(CMD_STAT_BYTE, 16'h0000, 1'b1); rc(CMD_STAT_BYTE, 16'h0002);
        wr(CMD_CLEAR, 16'h0000, KIND_SEND); wr(CMD_OV_THR, 16'h0000, pwl_kind_t'(2'h3));
        rc(CMD_OV_THR, 16'h0200); rc(CMD_STAT_BYTE, 16'h0002);
        wr(CMD_CLEAR, 16'h0000, KIND_SEND);
        @(posedge core_clk) #1 output_feedback_pin = 0;
        {outvolt_group_pending, outcurrent_group_pending, vendor_group_pending} = 3'h7;
        repeat (6) @(posedge core_clk); rc(CMD_STAT_WORD, 16'hd801);
        check({15'h0000, power_good_pin}, 16'h0000);
        @(posedge core_clk) #1 output_feedback_pin = 1;
        {outvolt_group_pending, outcurrent_group_pending, vendor_group_pending} = 3'h0;
        repeat (6) @(posedge core_clk); rc(CMD_STAT_WORD, 16'h0000);
        check({15'h0000, power_good_pin}, 16'h0001);
        $display("operation and errors done");
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge core_clk) if (++cyc == 5000) begin n_mismatch++; results; end
    initial begin
        rstn = 0; oc_timeout_pin = 0; uv_cmp_pin = 0; output_feedback_pin = 1; meas_valid = 0; vin_code = 0; pin_code = 0;
        {outvolt_group_pending, outcurrent_group_pending, vendor_group_pending} = 3'h0;
        repeat (16) @(posedge core_clk);
        #1 rstn = 1;
        repeat (4) @(posedge core_clk);
        t_reset; t_thr; t_warn; t_fault; t_misc;
        results;
    end
endmodule
`default_nettype wire

/* testbench/pwl_chk_assertions.sv */
// Checker for pwl_top: answers on the command port and fault gating.
// Assumes: bound onto pwl_top; rstn resets both clock domains.
`timescale 1ns/1ps
`default_nettype none
module pwl_chk (
    input wire logic        link_clk, core_clk, rstn, cmd_valid, cmd_busy, rsp_valid,
    input wire logic        oc_timeout_pin, gate_enable, output_feedback_pin, power_good_pin,
    input wire logic [7:0]  cmd_code,
    input wire logic [15:0] rsp_rdata
);
    logic [7:0] code_r, code_nxt;  // Code of the command in flight
    always_comb code_nxt = (cmd_valid && !cmd_busy) ? cmd_code : code_r;
    always_ff @(posedge link_clk or negedge rstn) if (!rstn) code_r <= 8'h00; else code_r <= code_nxt;
    default clocking @(posedge link_clk); endclocking
    default disable iff (!rstn);
    property p_rsp; cmd_valid && !cmd_busy |-> ##[2:40] rsp_valid; endproperty
    a_rsp: assert property (p_rsp) else $error("command never answered");
    property p_hold; !rsp_valid |-> $stable(rsp_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved between answers");
    property p_thr; rsp_valid && code_r inside {8'h57, 8'h58} |-> rsp_rdata[15:12] == 4'h0; endproperty
    a_thr: assert property (p_thr) else $error("voltage threshold top bits set");
    property p_op; rsp_valid && code_r == 8'h6b |-> !rsp_rdata[15]; endproperty
    a_op: assert property (p_op) else $error("power threshold top bit set");
    property p_byte; rsp_valid && code_r == 8'h78 |-> rsp_rdata[15:7] == 9'h000 && !rsp_rdata[5] && !rsp_rdata[2]; endproperty
    a_byte: assert property (p_byte) else $error("status byte spare bits set");
    property p_word; rsp_valid && code_r == 8'h79 |-> rsp_rdata[10:8] == 3'h0; endproperty
    a_word: assert property (p_word) else $error("status word spare bits set");
    property p_gate; @(posedge core_clk) oc_timeout_pin |-> ##[1:6] !gate_enable; endproperty
    a_gate: assert property (p_gate) else $error("gate stayed on after shutdown");
    property p_pg; @(posedge core_clk) $rose(output_feedback_pin) |-> ##[1:4] power_good_pin; endproperty
    a_pg: assert property (p_pg) else $error("power good did not follow feedback");
    c_word: cover property (rsp_valid && code_r == 8'h79);
    c_thr: cover property (rsp_valid && code_r == 8'h57);
    c_off: cover property (@(posedge core_clk) $fell(gate_enable));
endmodule
bind pwl_top pwl_chk pwl_chk_i (.*);
`default_nettype wire

/* testbench/pwl_host_model.sv */
// Host model: offers one command at a time on the link port.
// Assumes: the link clock it makes may stop between commands.
`timescale 1ns/1ps
`default_nettype none
module pwl_host_model (
    output logic               link_clk, cmd_valid, cmd_bad,
    output pwl_pkg::pwl_kind_t cmd_kind,
    output logic [7:0]         cmd_code,
    output logic [15:0]        cmd_wdata,
    input wire logic           cmd_busy, rsp_valid,
    input wire logic [15:0]    rsp_rdata
);
    import pwl_pkg::*;
    logic run;  // Link clock runs from start-up to the end of the first frame, then only inside a frame
    initial begin run = 1; link_clk = 0; cmd_valid = 0; cmd_bad = 0; cmd_kind = KIND_READ; cmd_code = 0; cmd_wdata = 0; end
    always #6 if (run) link_clk = ~link_clk;
    // One command, then wait for its answer
    task automatic xfer(input pwl_kind_t k, input logic [7:0] c, input logic [15:0] d, input logic b,
                        output logic [15:0] r);
        int n;
        run = 1;
        n = 0;
        repeat (2) @(posedge link_clk);
        #1 cmd_valid = 1; cmd_bad = b; cmd_kind = k; cmd_code = c; cmd_wdata = d;
        do begin @(posedge link_clk); #1 cmd_valid = 0; cmd_bad = 0; n++; end while (rsp_valid !== 1'b1 && n < 40);
        r = (rsp_valid === 1'b1) ? rsp_rdata : 16'hxxxx;  // No answer in time reads as unknown
        cmd_code = ~c;  // Released code and data lines never keep the last value
        cmd_wdata = ~d;
        run = 0;
    endtask
endmodule
`default_nettype wire
